//--- sram_host_pkg.sv
// Constants and types shared by the static memory host controller
// Notes on behaviour
// - Write while select and strobe low
// - Read: strobe high, select, gate low
// - Write spans both low, ends first rise
// - Address valid before select falls
// - No new read before cycle period
// - Deselect before retention, wait after restore
package sram_host_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int WORDS = 32768;
    localparam int CLOCK_NS = 40;
    // Chosen speed grade; period of read and write cycle
    localparam int READ_CYCLE_PERIOD_NS = 25;
    localparam int READ_CYCLE_CYCLES =
        (READ_CYCLE_PERIOD_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int DESELECT_TO_RETENTION_DELAY_NS = 0;
    localparam int DESELECT_TO_RETENTION_CYCLES = 1;
    localparam int RECOVERY_TIME_NS = READ_CYCLE_PERIOD_NS;
    localparam int RECOVERY_CYCLES = (RECOVERY_TIME_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int CNT_W = 4;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_READ,
        ST_WRITE,
        ST_RELEASE,
        ST_RETAIN,
        ST_RECOVER
    } host_state_t;
endpackage

//--- cycle_timer.sv
// Down counter that measures the spacing of memory cycles
`timescale 1ns/100ps
module cycle_timer #(
    parameter int WIDTH = 4
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    output logic done
);
    logic [WIDTH-1:0] remain;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            remain <= '0;
        end else if (load) begin
            remain <= count;
        end else if (remain != '0) begin
            remain <= remain - 1'b1;
        end
    end

    assign done = (remain == '0) && !load;
endmodule

//--- sram_host.sv
// Host controller that drives an asynchronous 32K by 8 static memory
`timescale 1ns/100ps
module sram_host #(
    parameter int READ_CYCLES = sram_host_pkg::READ_CYCLE_CYCLES,
    parameter int RECOVER_CYCLES = sram_host_pkg::RECOVERY_CYCLES
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [sram_host_pkg::ADDR_W-1:0] req_addr,
    input wire logic [sram_host_pkg::DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [sram_host_pkg::DATA_W-1:0] rsp_rdata,
    input wire logic retain_req,
    output logic retain_active,
    output logic [sram_host_pkg::ADDR_W-1:0] mem_addr,
    output logic chip_select_n,
    output logic output_gate_n,
    output logic write_strobe_n,
    input wire logic [sram_host_pkg::DATA_W-1:0] mem_data_in,
    output logic [sram_host_pkg::DATA_W-1:0] mem_data_out,
    output logic mem_data_oe
);
    localparam logic [sram_host_pkg::CNT_W-1:0] READ_CNT = READ_CYCLES[sram_host_pkg::CNT_W-1:0];
    localparam logic [sram_host_pkg::CNT_W-1:0] REC_CNT =
        RECOVER_CYCLES[sram_host_pkg::CNT_W-1:0];

    sram_host_pkg::host_state_t state;
    logic timer_load;
    logic timer_done;
    logic [sram_host_pkg::CNT_W-1:0] timer_count;
    logic req_w;

    cycle_timer #(
        .WIDTH(sram_host_pkg::CNT_W)
    ) u_timer (
        .clock(clock),
        .rst_b(rst_b),
        .load(timer_load),
        .count(timer_count),
        .done(timer_done)
    );

    // Timer starts whenever the strobes are entered or power returns
    always_comb begin
        timer_load = 1'b0;
        timer_count = READ_CNT;
        case (state)
            sram_host_pkg::ST_SETUP: begin
                timer_load = 1'b1;
            end
            sram_host_pkg::ST_RETAIN: begin
                timer_load = !retain_req;
                timer_count = REC_CNT;
            end
            default: begin
                timer_load = 1'b0;
            end
        endcase
    end

    assign req_ready = (state == sram_host_pkg::ST_IDLE) && !retain_req;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= sram_host_pkg::ST_IDLE;
        end else begin
            case (state)
                sram_host_pkg::ST_IDLE: begin
                    if (retain_req) begin
                        state <= sram_host_pkg::ST_RETAIN;
                    end else if (req_valid) begin
                        state <= sram_host_pkg::ST_SETUP;
                    end
                end
                sram_host_pkg::ST_SETUP: begin
                    state <= req_w ? sram_host_pkg::ST_WRITE : sram_host_pkg::ST_READ;
                end
                sram_host_pkg::ST_READ: begin
                    if (timer_done) begin
                        state <= sram_host_pkg::ST_RELEASE;
                    end
                end
                sram_host_pkg::ST_WRITE: begin
                    if (timer_done) begin
                        state <= sram_host_pkg::ST_RELEASE;
                    end
                end
                sram_host_pkg::ST_RELEASE: begin
                    state <= sram_host_pkg::ST_IDLE;
                end
                sram_host_pkg::ST_RETAIN: begin
                    if (!retain_req) begin
                        state <= sram_host_pkg::ST_RECOVER;
                    end
                end
                sram_host_pkg::ST_RECOVER: begin
                    if (timer_done) begin
                        state <= sram_host_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= sram_host_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Request captured while address settles ahead of select
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mem_addr <= '0;
            mem_data_out <= '0;
            req_w <= 1'b0;
        end else if (req_valid && req_ready) begin
            mem_addr <= req_addr;
            mem_data_out <= req_wdata;
            req_w <= req_write;
        end
    end

    // Strobes registered; write ends by strobe and select rising together
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            chip_select_n <= 1'b1;
            output_gate_n <= 1'b1;
            write_strobe_n <= 1'b1;
            mem_data_oe <= 1'b0;
        end else begin
            chip_select_n <= !((state == sram_host_pkg::ST_SETUP) ||
                ((state == sram_host_pkg::ST_READ || state == sram_host_pkg::ST_WRITE)
                && !timer_done));
            output_gate_n <= !((state == sram_host_pkg::ST_SETUP && !req_w) ||
                (state == sram_host_pkg::ST_READ && !timer_done));
            write_strobe_n <= !((state == sram_host_pkg::ST_SETUP && req_w) ||
                (state == sram_host_pkg::ST_WRITE && !timer_done));
            mem_data_oe <= (state == sram_host_pkg::ST_SETUP && req_w) ||
                (state == sram_host_pkg::ST_WRITE);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= (state == sram_host_pkg::ST_READ || state == sram_host_pkg::ST_WRITE)
                && timer_done;
            if (state == sram_host_pkg::ST_READ && timer_done) begin
                rsp_rdata <= mem_data_in;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            retain_active <= 1'b0;
        end else begin
            retain_active <= (state == sram_host_pkg::ST_RETAIN) && retain_req;
        end
    end

    property p_no_contention;
        @(posedge clock) disable iff (!rst_b)
        (!chip_select_n && !output_gate_n) |-> !mem_data_oe;
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("host drives during read");

    property p_write_needs_select;
        @(posedge clock) disable iff (!rst_b)
        !write_strobe_n |-> !chip_select_n && output_gate_n && mem_data_oe;
    endproperty
    a_write_needs_select: assert property (p_write_needs_select) else $error("bad write");

    sequence s_select_rise;
        !chip_select_n ##1 chip_select_n;
    endsequence
    property p_addr_stable;
        @(posedge clock) disable iff (!rst_b)
        !chip_select_n ##1 !chip_select_n |-> $stable(mem_addr);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved");

    property p_idle_after_cycle;
        @(posedge clock) disable iff (!rst_b)
        s_select_rise |-> write_strobe_n && output_gate_n;
    endproperty
    a_idle_after_cycle: assert property (p_idle_after_cycle) else $error("strobe left low");

    property p_select_length;
        @(posedge clock) disable iff (!rst_b)
        $fell(chip_select_n) |-> !chip_select_n [*2];
    endproperty
    a_select_length: assert property (p_select_length) else $error("cycle too short");

    property p_retain_deselected;
        @(posedge clock) disable iff (!rst_b)
        retain_active |-> chip_select_n && !mem_data_oe;
    endproperty
    a_retain_deselected: assert property (p_retain_deselected) else $error("selected");

    property p_rsp_after_select;
        @(posedge clock) disable iff (!rst_b)
        $rose(rsp_valid) |-> $past(!chip_select_n);
    endproperty
    a_rsp_after_select: assert property (p_rsp_after_select) else $error("stray answer");

    property p_ready_idle;
        @(posedge clock) disable iff (!rst_b)
        req_ready |-> chip_select_n ##1 1'b1;
    endproperty
    a_ready_idle: assert property (p_ready_idle) else $error("ready while selected");
endmodule

//--- sram_model.sv
// Behavioural model of the 32K by 8 static memory
`timescale 1ns/100ps
module sram_model (
    input wire logic [sram_host_pkg::ADDR_W-1:0] addr,
    input wire logic chip_select_n,
    input wire logic output_gate_n,
    input wire logic write_strobe_n,
    input wire logic [sram_host_pkg::DATA_W-1:0] host_data,
    input wire logic host_oe,
    output logic [sram_host_pkg::DATA_W-1:0] bus
);
    logic [sram_host_pkg::DATA_W-1:0] mem [sram_host_pkg::WORDS];
    logic [sram_host_pkg::DATA_W-1:0] float_val = 8'h5A;
    logic drive;
    // Undriven bus shows a changing pattern
    always #20 float_val = ~float_val;
    assign drive = !chip_select_n && !output_gate_n && write_strobe_n;
    // Read path follows the address with no strobe
    assign bus = drive ? mem[addr] : (host_oe ? host_data : float_val);
    always @* begin
        if (!chip_select_n && !write_strobe_n) begin
            mem[addr] = bus;
        end
    end
endmodule

//--- sram_host_tb.sv
// Self-checking bench for the static memory host controller
`timescale 1ns/100ps
module sram_host_tb;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [14:0] req_addr = 15'h0000;
    logic [7:0] req_wdata = 8'h00;
    logic retain_req = 1'b0;
    logic req_ready, rsp_valid, retain_active, chip_select_n, output_gate_n, write_strobe_n;
    logic mem_data_oe;
    logic [7:0] rsp_rdata, mem_data_out, bus;
    logic [14:0] mem_addr;
    int failures = 0;
    int samples_checked = 0;
    sram_host dut (.clock(clock), .rst_b(rst_b), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .retain_req(retain_req), .retain_active(retain_active), .mem_addr(mem_addr),
        .chip_select_n(chip_select_n), .output_gate_n(output_gate_n),
        .write_strobe_n(write_strobe_n), .mem_data_in(bus), .mem_data_out(mem_data_out),
        .mem_data_oe(mem_data_oe));
    sram_model mem (.addr(mem_addr), .chip_select_n(chip_select_n),
        .output_gate_n(output_gate_n), .write_strobe_n(write_strobe_n),
        .host_data(mem_data_out), .host_oe(mem_data_oe), .bus(bus));
    initial begin
        forever #20 clock = ~clock;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // One memory cycle; returns the read word
    task automatic op(input logic w, input logic [14:0] a, input logic [7:0] d,
            output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clock);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        // Request held until an edge that finds ready high
        @(negedge clock);
        while (!req_ready && n < 20) begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(negedge clock);
            n++;
            if (n == 2) begin
                check("ready_busy", req_ready, 0);
                check("select", chip_select_n, 0);
                check("strobe", write_strobe_n, !w);
                check("host_oe", mem_data_oe, w);
                check("gate", output_gate_n, w);
                check("addr", mem_addr, a);
                if (w) begin
                    check("wdata", mem_data_out, d);
                end
            end
        end while (!rsp_valid && n < 20);
        check("latency", n, 4);
        check("released", {chip_select_n, output_gate_n, write_strobe_n}, 3'b111);
        q = rsp_rdata;
    endtask
    task automatic write_read(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] q;
        op(1'b1, a, d, q);
        op(1'b0, a, 8'h00, q);
        check("rdata", q, d);
    endtask
    task automatic retention(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] q;
        int n;
        op(1'b1, a, d, q);
        @(posedge clock);
        retain_req <= 1'b1;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (!retain_active && n < 10);
        check("retain", retain_active, 1);
        check("deselect", chip_select_n, 1);
        check("ready_retain", req_ready, 0);
        @(posedge clock);
        retain_req <= 1'b0;
        @(negedge clock);
        check("ready_recover", req_ready, 0);
        op(1'b0, a, 8'h00, q);
        check("kept", q, d);
    endtask
    // Host must not drive while the memory drives
    always @(negedge clock) begin
        if (rst_b && !chip_select_n && !output_gate_n && write_strobe_n) begin
            check("contention", mem_data_oe, 0);
        end
    end
    initial begin
        #(40 * 3000);
        failures++;
        finish_test;
    end
    initial begin
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        @(negedge clock);
        check("rst_cs", chip_select_n, 1);
        check("rst_oe", mem_data_oe, 0);
        write_read(15'h0000, 8'hA5);
        write_read(15'h7FFF, 8'h3C);
        write_read(15'h1234, 8'hFF);
        write_read(15'h4321, 8'h00);
        write_read(15'h0000, 8'h5A);
        retention(15'h2AAA, 8'hC3);
        finish_test;
    end
endmodule
